// ### src/upsc_pkg.sv
package upsc_pkg;
	// Clock period in ns (10 MHz)
	localparam int unsigned CLK_PERIOD_NS = 100;
	// Discharge pulse time in us, least time rounds up
	localparam int unsigned DISCHARGE_PULSE_US = 200;
	localparam int unsigned DISCHARGE_CYCLES =
		(DISCHARGE_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Idle time before falling back to sleep, in ms
	localparam int unsigned IDLE_SLEEP_MS = 10;
	localparam int unsigned IDLE_SLEEP_CYCLES = IDLE_SLEEP_MS * 1000000 / CLK_PERIOD_NS;
	// Fault retry interval, in ms
	localparam int unsigned RETRY_MS = 50;
	localparam int unsigned RETRY_CYCLES = RETRY_MS * 1000000 / CLK_PERIOD_NS;
	// Timer width
	localparam int unsigned TMR_W = 24;
	// Strap codes from the resistor sense comparator
	localparam logic [2:0] STRAP_GND = 3'h0;
	localparam logic [2:0] STRAP_10K = 3'h1;
	localparam logic [2:0] STRAP_12K = 3'h2;
	localparam logic [2:0] STRAP_15K = 3'h3;
	localparam logic [2:0] STRAP_18K = 3'h4;
	// Current limit settings in units of 10 mA
	localparam logic [8:0] ILIM_053 = 9'h035;
	localparam logic [8:0] ILIM_096 = 9'h060;
	localparam logic [8:0] ILIM_107 = 9'h06b;
	localparam logic [8:0] ILIM_128 = 9'h080;
	localparam logic [8:0] ILIM_160 = 9'h0a0;
	// Power states
	typedef enum logic [2:0] {
		ST_SLEEP, ST_DETECT, ST_ARM, ST_DISCH, ST_ACTIVE, ST_ERROR
	} upsc_state_t;
endpackage

// ### src/upsc_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for pin inputs
module upsc_sync #(
	parameter int unsigned W = 1
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	// First stage, read only by the second
	logic [W-1:0] meta_q;
	// Two stages in series
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

// ### src/upsc_strap.sv
`timescale 1ns/1ns
// Strap decoder: mode and current limit from the resistor code
module upsc_strap (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic [2:0] strap_code_i,
	input wire logic capture_i,
	output logic smbus_mode_o,
	output logic enable_active_high_o,
	output logic [8:0] current_limit_setting_o
);
	// Constant lookup of strap code
	function automatic logic [9:0] strap_lookup(input logic [2:0] code);
		unique case (code)
			upsc_pkg::STRAP_GND: strap_lookup = {1'b1, upsc_pkg::ILIM_053};
			upsc_pkg::STRAP_10K: strap_lookup = {1'b1, upsc_pkg::ILIM_096};
			upsc_pkg::STRAP_12K: strap_lookup = {1'b1, upsc_pkg::ILIM_107};
			upsc_pkg::STRAP_15K: strap_lookup = {1'b1, upsc_pkg::ILIM_128};
			upsc_pkg::STRAP_18K: strap_lookup = {1'b1, upsc_pkg::ILIM_160};
			// Unlisted codes fall back to the lowest limit
			default: strap_lookup = {1'b1, upsc_pkg::ILIM_053};
		endcase
	endfunction
	// Latch the decode once, after reset release
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			smbus_mode_o <= 1'b1;
			current_limit_setting_o <= upsc_pkg::ILIM_053;
		end else if (capture_i) begin
			{smbus_mode_o, current_limit_setting_o} <= strap_lookup(strap_code_i);
		end
	end
	// Every listed code selects active-high enables
	assign enable_active_high_o = 1'b1;
endmodule

// ### src/upsc_power_ctrl.sv
`timescale 1ns/1ns
module upsc_power_ctrl #(
	parameter int unsigned IDLE_SLEEP_CYCLES = upsc_pkg::IDLE_SLEEP_CYCLES,
	parameter int unsigned RETRY_CYCLES = upsc_pkg::RETRY_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Port enable pins, one bit per port
	input wire logic [1:0] port_power_enable_i,
	// Strap resistor code from the sense comparator
	input wire logic [2:0] comm_limit_select_pin_i,
	// Analog comparator flags, per port, then shared over-temperature and source UV/OV flags
	input wire logic [1:0] attach_event_i,
	input wire logic [1:0] removal_event_i,
	input wire logic [1:0] back_drive_i,
	input wire logic [1:0] overcurrent_i,
	input wire logic [1:0] bus_undervoltage_i,
	input wire logic [1:0] discharge_error_i,
	input wire logic over_temp_i,
	input wire logic source_uv_i,
	input wire logic source_ov_i,
	// Fault handling selection: high for auto-recovery
	input wire logic auto_recover_i,
	// Serial bus byte events from the bus engine (same clock)
	input wire logic bus_byte_read_i,
	input wire logic bus_byte_write_i,
	input wire logic [7:0] bus_rdata_i,
	output logic [7:0] bus_rdata_o,
	output logic awake_o,
	// Switch controls and status, per port, then the strap mode and current limit
	output logic [1:0] port_switch_o,
	output logic [1:0] bypass_switch_o,
	output logic [1:0] discharge_switch_o,
	output logic [1:0] attach_det_en_o,
	output logic [1:0] removal_det_en_o,
	output logic [1:0] alert_b_o,
	output logic [1:0] in_error_o,
	output logic smbus_mode_o,
	output logic [8:0] current_limit_setting_o
);
	// Synchronised pin inputs
	logic [1:0] en_s;
	logic [1:0] att_s, rem_s, bd_s, oc_s, buv_s, de_s;
	logic [2:0] misc_s;
	logic ot_s, suv_s, sov_s;
	// Strap capture done flag; the capture pulse comes two cycles after release
	logic strap_done_q;

	upsc_sync #(.W(2)) u_sync_en (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .d_i(port_power_enable_i), .q_o(en_s));
	upsc_sync #(.W(12)) u_sync_port (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.d_i({attach_event_i, removal_event_i, back_drive_i, overcurrent_i,
			bus_undervoltage_i, discharge_error_i}),
		.q_o({att_s, rem_s, bd_s, oc_s, buv_s, de_s}));
	upsc_sync #(.W(3)) u_sync_misc (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.d_i({over_temp_i, source_uv_i, source_ov_i}), .q_o(misc_s));
	assign {ot_s, suv_s, sov_s} = misc_s;

	// Strap decode, captured after the synchroniser settles
	logic [2:0] strap_s;
	logic [1:0] strap_cnt_q;
	logic unused_pol;
	upsc_sync #(.W(3)) u_sync_strap (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .d_i(comm_limit_select_pin_i),
		.q_o(strap_s));
	upsc_strap u_strap (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .strap_code_i(strap_s),
		.capture_i(strap_cnt_q == 2'h2 && !strap_done_q),
		.smbus_mode_o(smbus_mode_o), .enable_active_high_o(unused_pol),
		.current_limit_setting_o(current_limit_setting_o));
	// Strap capture sequencing
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strap_cnt_q <= 2'h0;
			strap_done_q <= 1'b0;
		end else if (strap_cnt_q != 2'h2) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
		end else begin
			strap_done_q <= 1'b1;
		end
	end

	// Device sleeps when both enables are low (AND of inactive levels)
	logic sleep_req;
	assign sleep_req = !en_s[0] && !en_s[1];

	// Wake logic: first sleep read wakes, idle timer returns to sleep
	logic awake_q;
	logic [upsc_pkg::TMR_W-1:0] idle_q;
	logic bus_act;
	assign bus_act = bus_byte_read_i || bus_byte_write_i;
	// Awake flag and idle counter
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			awake_q <= 1'b0;
			idle_q <= '0;
		end else if (!sleep_req) begin
			awake_q <= 1'b1;
			idle_q <= '0;
		end else if (!awake_q) begin
			// Dummy read wakes the device
			if (bus_byte_read_i) begin
				awake_q <= 1'b1;
				idle_q <= '0;
			end
		end else if (bus_act) begin
			idle_q <= '0;
		end else if (idle_q == upsc_pkg::TMR_W'(IDLE_SLEEP_CYCLES - 1)) begin
			awake_q <= 1'b0;
			idle_q <= '0;
		end else begin
			idle_q <= idle_q + 1'b1;
		end
	end
	assign awake_o = awake_q;
	// Read data: zeros for the wake byte
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus_rdata_o <= 8'h00;
		end else if (bus_byte_read_i) begin
			bus_rdata_o <= (awake_q || !sleep_req) ? bus_rdata_i : 8'h00;
		end
	end

	// Per-channel state machines; port faults stay on their own channel, over-temperature and source OV fault both
	upsc_pkg::upsc_state_t st_q [2];
	logic [upsc_pkg::TMR_W-1:0] tmr_q [2];

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic fault_act, fault_det, fault_slp, fault_any, can_act;
			// Fault sets by state of origin
			assign fault_act = ot_s || oc_s[g] || buv_s[g] || bd_s[g] || de_s[g] || sov_s;
			assign fault_det = bd_s[g] || ot_s;
			assign fault_slp = bd_s[g];
			assign fault_any = fault_act;
			// Active only with enable and source above UV
			assign can_act = en_s[g] && !suv_s;
			// Channel state machine
			always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					st_q[g] <= upsc_pkg::ST_SLEEP;
					tmr_q[g] <= '0;
				end else begin
					unique case (st_q[g])
						upsc_pkg::ST_SLEEP: begin
							if (fault_slp) begin
								st_q[g] <= upsc_pkg::ST_ERROR;
								tmr_q[g] <= '0;
							end else if (!sleep_req && en_s[g]) begin
								st_q[g] <= upsc_pkg::ST_DETECT;
							end
						end
						upsc_pkg::ST_DETECT: begin
							if (fault_det) begin
								st_q[g] <= upsc_pkg::ST_ERROR;
								tmr_q[g] <= '0;
							end else if (sleep_req || !en_s[g]) begin
								st_q[g] <= upsc_pkg::ST_SLEEP;
							end else if (att_s[g] && can_act) begin
								st_q[g] <= upsc_pkg::ST_ARM;
							end
						end
						upsc_pkg::ST_ARM: begin
							// Attach detect off, bypass off for one cycle
							st_q[g] <= upsc_pkg::ST_DISCH;
							tmr_q[g] <= '0;
						end
						upsc_pkg::ST_DISCH: begin
							if (!can_act) begin
								st_q[g] <= upsc_pkg::ST_DETECT;
							end else if (tmr_q[g] ==
								upsc_pkg::TMR_W'(upsc_pkg::DISCHARGE_CYCLES - 1)) begin
								st_q[g] <= upsc_pkg::ST_ACTIVE;
							end else begin
								tmr_q[g] <= tmr_q[g] + 1'b1;
							end
						end
						upsc_pkg::ST_ACTIVE: begin
							if (fault_act) begin
								st_q[g] <= upsc_pkg::ST_ERROR;
								tmr_q[g] <= '0;
							end else if (!can_act) begin
								st_q[g] <= sleep_req ? upsc_pkg::ST_SLEEP
									: upsc_pkg::ST_DETECT;
							end else if (rem_s[g]) begin
								st_q[g] <= upsc_pkg::ST_DETECT;
							end
						end
						upsc_pkg::ST_ERROR: begin
							// Recheck on retry expiry or on removal
							if ((auto_recover_i && tmr_q[g] ==
								upsc_pkg::TMR_W'(RETRY_CYCLES - 1)) || rem_s[g]) begin
								tmr_q[g] <= '0;
								if (!fault_any) begin
									// Return as the settings define
									st_q[g] <= sleep_req ? upsc_pkg::ST_SLEEP
										: (can_act && !rem_s[g]) ? upsc_pkg::ST_ARM
										: upsc_pkg::ST_DETECT;
								end
							end else if (auto_recover_i) begin
								tmr_q[g] <= tmr_q[g] + 1'b1;
							end
						end
						default: st_q[g] <= upsc_pkg::ST_SLEEP;
					endcase
				end
			end

			// Outputs registered from current-state decode, one cycle behind the state
			always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
				if (!rst_b_i) begin
					port_switch_o[g] <= 1'b0;
					bypass_switch_o[g] <= 1'b0;
					discharge_switch_o[g] <= 1'b0;
					attach_det_en_o[g] <= 1'b0;
					removal_det_en_o[g] <= 1'b0;
					alert_b_o[g] <= 1'b1;
					in_error_o[g] <= 1'b0;
				end else begin
					port_switch_o[g] <= st_q[g] == upsc_pkg::ST_ACTIVE && can_act;
					bypass_switch_o[g] <= st_q[g] == upsc_pkg::ST_DETECT;
					discharge_switch_o[g] <= st_q[g] == upsc_pkg::ST_DISCH;
					attach_det_en_o[g] <= st_q[g] == upsc_pkg::ST_DETECT;
					removal_det_en_o[g] <= st_q[g] != upsc_pkg::ST_SLEEP;
					alert_b_o[g] <= st_q[g] != upsc_pkg::ST_ERROR;
					in_error_o[g] <= st_q[g] == upsc_pkg::ST_ERROR;
				end
			end

			// Port switch only closes in Active
			a_port_switch_active: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
				port_switch_o[g] |-> $past(st_q[g]) == upsc_pkg::ST_ACTIVE)
				else $error("port switch closed outside active");
			// Error keeps both switches open
			a_error_switches_open: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
				st_q[g] == upsc_pkg::ST_ERROR |=> !port_switch_o[g] && !bypass_switch_o[g]
				&& !alert_b_o[g])
				else $error("switch closed or alert released in error");
			// Sleep releases alert and grounds outputs
			a_sleep_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
				st_q[g] == upsc_pkg::ST_SLEEP |=> alert_b_o[g] && !bypass_switch_o[g]
				&& !port_switch_o[g] && !attach_det_en_o[g])
				else $error("sleep outputs wrong");
			// Attach moves detect toward active
			a_attach_to_arm: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
				st_q[g] == upsc_pkg::ST_DETECT && att_s[g] && can_act && !fault_det
				&& !sleep_req |=> st_q[g] == upsc_pkg::ST_ARM)
				else $error("attach did not start activation");
			// Discharge precedes switch close
			a_disch_then_close: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
				$rose(port_switch_o[g]) |-> $past(discharge_switch_o[g]) && !bypass_switch_o[g])
				else $error("port switch closed without discharge");
			// Active fault enters error next cycle
			a_active_fault: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
				st_q[g] == upsc_pkg::ST_ACTIVE && fault_act |=> st_q[g] == upsc_pkg::ST_ERROR)
				else $error("active fault missed");
			// Sleep back-drive enters error
			a_sleep_backdrive: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
				st_q[g] == upsc_pkg::ST_SLEEP && bd_s[g] |=> st_q[g] == upsc_pkg::ST_ERROR)
				else $error("sleep back-drive missed");
		end
	endgenerate

	// Wake byte returns zeros
	a_wake_read_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!awake_q && sleep_req && bus_byte_read_i |=> bus_rdata_o == 8'h00 && awake_q)
		else $error("wake read not zero");
	// Sleep decision follows both enables
	a_sleep_and: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		!sleep_req |=> awake_q)
		else $error("not awake with an enable set");
endmodule

// ### dv/upsc_far_model.sv
`timescale 1ns/1ns
// Far side: a bus host moving single bytes, and a device on each port
module upsc_far_model (
	input wire logic ref_clk_i,
	output logic bus_byte_read_o,
	output logic bus_byte_write_o,
	output logic [7:0] bus_rdata_o,
	output logic [1:0] attach_event_o,
	output logic [1:0] removal_event_o
);
	logic [7:0] data_q; // Byte offered during a read
	logic [7:0] noise_q; // Changing pattern outside reads
	initial begin
		{bus_byte_read_o, bus_byte_write_o} = 2'h0;
		{attach_event_o, removal_event_o} = 4'h0;
		{data_q, noise_q} = 16'h0000;
	end
	// Read data is only meaningful while a read is in flight
	always @(negedge ref_clk_i) noise_q <= noise_q + 8'h35;
	assign bus_rdata_o = bus_byte_read_o ? data_q : noise_q;
	// One byte per transfer, never a block
	task automatic xfer(input logic rd, input logic [7:0] d);
		@(negedge ref_clk_i);
		data_q = d;
		bus_byte_read_o = rd;
		bus_byte_write_o = !rd;
		@(negedge ref_clk_i);
		{bus_byte_read_o, bus_byte_write_o} = 2'h0;
	endtask
	// Plug a device in or out of one port
	task automatic plug(input int ch, input logic att);
		@(negedge ref_clk_i);
		if (att) attach_event_o[ch] = 1'b1;
		else removal_event_o[ch] = 1'b1;
		@(negedge ref_clk_i);
		{attach_event_o, removal_event_o} = 4'h0;
	endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ns
// Power-state bench: drives pins at the falling edge, checks outputs
module testbench;
	localparam int IDLE = 20;
	localparam int RETRY = 30;
	localparam int DISCH = upsc_pkg::DISCHARGE_CYCLES;
	logic ref_clk_i, rst_b_i, auto_recover_i, source_uv_i, rd, wr;
	logic [1:0] en, att, rem;
	logic [2:0] strap;
	logic [5:0] flt; // Fault stimulus, one bit per fault kind
	logic [7:0] rdi, bus_rdata_o, d;
	logic awake_o, smbus_mode_o;
	logic [1:0] port_switch_o, bypass_switch_o, discharge_switch_o;
	logic [1:0] attach_det_en_o, removal_det_en_o, alert_b_o, in_error_o;
	logic [8:0] current_limit_setting_o;
	logic [8:0] lim_tab [6] = '{9'h035, 9'h060, 9'h06b, 9'h080, 9'h0a0, 9'h035};
	logic [7:0] exp_q [$]; // Expected read bytes, oldest first
	logic [31:0] seed = 32'hc82020ad;
	int fails = 0;
	int checked = 0;
	int n, f;

	upsc_power_ctrl #(.IDLE_SLEEP_CYCLES(IDLE), .RETRY_CYCLES(RETRY)) DUT (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .port_power_enable_i(en),
		.comm_limit_select_pin_i(strap), .attach_event_i(att), .removal_event_i(rem),
		.back_drive_i({1'b0, flt[3]}), .overcurrent_i({1'b0, flt[0]}),
		.bus_undervoltage_i({1'b0, flt[1]}), .discharge_error_i({1'b0, flt[2]}),
		.over_temp_i(flt[4]), .source_uv_i(source_uv_i), .source_ov_i(flt[5]),
		.auto_recover_i(auto_recover_i), .bus_byte_read_i(rd), .bus_byte_write_i(wr),
		.bus_rdata_i(rdi), .bus_rdata_o(bus_rdata_o), .awake_o(awake_o),
		.port_switch_o(port_switch_o), .bypass_switch_o(bypass_switch_o),
		.discharge_switch_o(discharge_switch_o), .attach_det_en_o(attach_det_en_o),
		.removal_det_en_o(removal_det_en_o), .alert_b_o(alert_b_o),
		.in_error_o(in_error_o), .smbus_mode_o(smbus_mode_o),
		.current_limit_setting_o(current_limit_setting_o));
	upsc_far_model far (.ref_clk_i(ref_clk_i), .bus_byte_read_o(rd),
		.bus_byte_write_o(wr), .bus_rdata_o(rdi), .attach_event_o(att),
		.removal_event_o(rem));

	// Clock, 100 ns period
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// Xorshift source for bus data
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Level comparison
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Read byte comparison
	task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("FAIL bus_rdata_o expected %h seen %h", e, g);
		end
	endtask
	// Takes the oldest note whenever a read byte comes out
	always @(posedge ref_clk_i) begin
		if (rd === 1'b1) begin
			@(negedge ref_clk_i);
			chk_rd((exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, bus_rdata_o);
		end
	end
	// Holds reset for 20 cycles with a strap code applied
	task automatic reset_dut(input logic [2:0] code);
		@(negedge ref_clk_i);
		rst_b_i = 1'b0;
		strap = code;
		repeat (20) @(negedge ref_clk_i);
		rst_b_i = 1'b1;
		repeat (6) @(negedge ref_clk_i);
	endtask
	// Verdict and end of run
	task automatic test_done();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Watchdog, well past the expected run length
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		fails++;
		test_done();
	end

	// Main sequence
	initial begin
		{rst_b_i, en, strap, flt, auto_recover_i, source_uv_i} = 14'h0002;
		for (f = 0; f < 6; f++) begin
			reset_dut(3'(f));
			chk("limit", 16'(lim_tab[f]), 16'(current_limit_setting_o));
			chk("mode", 16'h1, 16'(smbus_mode_o));
			chk("sleep", 16'h30, 16'({alert_b_o, port_switch_o, bypass_switch_o}));
		end
		$display("test strap done");
		@(negedge ref_clk_i);
		rst_b_i = 1'b0;
		exp_q.push_back(8'h00);
		far.xfer(1'b1, rnd());
		chk("awake off", 16'h0, 16'(awake_o));
		reset_dut(3'h1);
		exp_q.push_back(8'h00); // Dummy byte, discarded by the host
		far.xfer(1'b1, rnd());
		chk("awake", 16'h1, 16'(awake_o));
		d = rnd();
		exp_q.push_back(d);
		far.xfer(1'b1, d);
		far.xfer(1'b0, rnd());
		repeat (IDLE - 5) @(negedge ref_clk_i);
		chk("still awake", 16'h1, 16'(awake_o));
		repeat (10) @(negedge ref_clk_i);
		chk("idle sleep", 16'h0, 16'(awake_o));
		$display("test wake done");
		en = 2'h1;
		repeat (8) @(negedge ref_clk_i);
		chk("detect", 16'h5, 16'({port_switch_o, bypass_switch_o, attach_det_en_o}));
		far.plug(0, 1'b1);
		for (n = 0; n < 12 && bypass_switch_o[0] !== 1'b0; n++) @(negedge ref_clk_i);
		chk("arm", 16'h1, 16'({discharge_switch_o[0], attach_det_en_o[0], removal_det_en_o[0]}));
		for (n = 0; n < 5 && discharge_switch_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
		for (n = 0; n < 3000 && discharge_switch_o[0] === 1'b1; n++) @(negedge ref_clk_i);
		chk("pulse", 16'(DISCH), 16'(n));
		chk("active", 16'h4, 16'({port_switch_o, bypass_switch_o}));
		$display("test activate done");
		for (f = 0; f < 6; f++) begin
			@(negedge ref_clk_i);
			flt = 6'(1 << f);
			for (n = 0; n < 10 && in_error_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
			repeat (RETRY + 10) @(negedge ref_clk_i);
			chk("error", 16'h1, 16'({port_switch_o[0], bypass_switch_o[0], alert_b_o[0], in_error_o[0]}));
			if (f < 4) chk("other", 16'h0, 16'(in_error_o[1]));
			flt = 6'h00;
			for (n = 0; n < 3000 && port_switch_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
			chk("recover", 16'h3, 16'({in_error_o[0], alert_b_o[0], port_switch_o[0]}));
		end
		$display("test active faults done");
		auto_recover_i = 1'b0;
		flt = 6'h01;
		for (n = 0; n < 10 && in_error_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
		flt = 6'h00;
		repeat (3 * RETRY) @(negedge ref_clk_i);
		chk("held", 16'h1, 16'(in_error_o[0]));
		far.plug(0, 1'b0);
		for (n = 0; n < 15 && bypass_switch_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
		chk("removed", 16'h2, 16'({in_error_o[0], bypass_switch_o[0], port_switch_o[0]}));
		auto_recover_i = 1'b1;
		for (f = 3; f < 5; f++) begin
			@(negedge ref_clk_i);
			flt = 6'(1 << f);
			for (n = 0; n < 10 && in_error_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
			chk("detect fault", 16'h1, 16'({port_switch_o[0], bypass_switch_o[0], alert_b_o[0], in_error_o[0]}));
			flt = 6'h00;
			// Retry with the port enabled and no undervoltage rearms the port
			for (n = 0; n < 3000 && port_switch_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
			chk("detect back", 16'h1, 16'({in_error_o[0], port_switch_o[0]}));
			// Unplug to return to Detect before the next fault
			far.plug(0, 1'b0);
			repeat (6) @(negedge ref_clk_i);
			chk("re-detect", 16'h1, 16'(bypass_switch_o[0]));
		end
		$display("test removal and detect faults done");
		source_uv_i = 1'b1;
		far.plug(0, 1'b1);
		repeat (DISCH + 100) @(negedge ref_clk_i);
		chk("uv hold", 16'h0, 16'(port_switch_o[0]));
		source_uv_i = 1'b0;
		en = 2'h0;
		repeat (8) @(negedge ref_clk_i);
		chk("sleep", 16'h300, 16'({alert_b_o, port_switch_o, bypass_switch_o, attach_det_en_o, removal_det_en_o}));
		flt = 6'h08;
		for (n = 0; n < 10 && in_error_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
		chk("sleep fault", 16'h1, 16'({alert_b_o[0], in_error_o[0]}));
		flt = 6'h00;
		for (n = 0; n < 3 * RETRY && alert_b_o[0] !== 1'b1; n++) @(negedge ref_clk_i);
		chk("sleep again", 16'hc0, 16'({alert_b_o, in_error_o, port_switch_o, bypass_switch_o}));
		$display("test sleep done");
		test_done();
	end
endmodule
